// File: core/bus_match_host.sv
// Host end: sends and receives 36-bit words over the right port.
`timescale 1ns/1ps
`include "bus_match_cfg.svh"
module bus_match_host (
  input  wire logic        clk,        // 10 MHz clock.
  input  wire logic        rst_n,      // Asynchronous reset, active low.
  right_port_if.host       port,       // Right-port pins.
  input  wire logic        cfg_match,  // Narrow port wanted.
  input  wire logic        cfg_size,   // Byte width when narrow.
  input  wire logic        cfg_order,  // Big-endian order when narrow.
  input  wire logic        req,        // Start a word transfer.
  input  wire logic        req_write,  // Transfer is a write.
  input  wire logic [35:0] req_data,   // Word to write.
  output logic             ready,      // Idle and configured.
  output logic      [35:0] rsp_data,   // Word read back.
  output logic             rsp_valid   // Pulse when a read word is done.
);
  logic        match_q;
  logic        size_q;
  logic        order_q;
  logic        cfg_ok_q;
  logic        busy;
  logic        write_q;
  logic        first_q;
  logic [1:0]  cnt_q;
  logic [1:0]  idx_q;
  logic [35:0] wdata_q;
  logic [35:0] rdata_q;
  logic [1:0]  pieces;
  logic [1:0]  rd_idx;
  logic        rd_q;
  logic [1:0]  rd_slot_q;
  logic [35:0] rd_merge;

  // Sequencer state, one-hot.
  bus_match_pkg::seq_t state_q;
  bus_match_pkg::seq_t state_d;

  // Pins sampled every idle cycle and held; changes only when idle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      match_q  <= 1'b0;
      size_q   <= 1'b0;
      order_q  <= 1'b0;
      cfg_ok_q <= 1'b0;
    end
    else if (!busy)
    begin
      match_q  <= cfg_match;
      size_q   <= cfg_size;
      order_q  <= cfg_order;
      cfg_ok_q <= (cfg_match == match_q) && (cfg_size == size_q)
                  && (cfg_order == order_q);
    end
  end

  // Index of the final piece of a word for the latched width.
  always_comb
  begin
    if (!match_q)
      pieces = `RP_SUB_ZERO;
    else if (size_q)
      pieces = `RP_SUB_LAST;
    else
      pieces = `RP_SUB_HALF;
  end

  // Ready once idle and the selects have stood still for a cycle.
  assign ready  = !busy && cfg_ok_q;

  // Word sequencer: a taken request starts a word, the final piece ends it.
  always_comb
  begin
    case (state_q)
      bus_match_pkg::SEQ_IDLE:
        state_d = (req && ready) ? bus_match_pkg::SEQ_RUN : bus_match_pkg::SEQ_IDLE;
      bus_match_pkg::SEQ_RUN:
        state_d = (cnt_q == pieces) ? bus_match_pkg::SEQ_IDLE : bus_match_pkg::SEQ_RUN;
      default:
        state_d = bus_match_pkg::SEQ_IDLE;
    endcase
  end

  // State register, reset to SEQ_IDLE.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= bus_match_pkg::SEQ_IDLE;
    else
      state_q <= state_d;
  end

  // Busy while a word is on the port.
  assign busy = (state_q == bus_match_pkg::SEQ_RUN);

  // Per-word bookkeeping: the word, its piece count and its lane index.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_q <= 1'b0;
      first_q <= 1'b0;
      cnt_q   <= `RP_SUB_ZERO;
      idx_q   <= `RP_SUB_ZERO;
      wdata_q <= '0;
    end
    else if (!busy)
    begin
      first_q <= 1'b1;
      if (req && ready)
      begin
        write_q <= req_write;
        wdata_q <= req_data;
        cnt_q   <= `RP_SUB_ZERO;
        idx_q   <= (match_q && order_q) ? pieces : `RP_SUB_ZERO;
      end
    end
    else
    begin
      first_q <= 1'b0;
      cnt_q   <= cnt_q + `RP_SUB_STEP;
      idx_q   <= order_q ? idx_q - `RP_SUB_STEP : idx_q + `RP_SUB_STEP;
    end
  end

  // Pin drive: narrow write pieces placed on low lines, a long word on all lines; others left undriven.
  always_comb
  begin
    port.width_match_select = match_q;
    port.size_select        = size_q;
    port.lane_order_select  = order_q;
    port.access             = busy;
    port.write              = write_q;
    port.first              = busy && first_q;
    port.host_dq_o          = '0;
    port.host_dq_oe_n       = '1;
    if (busy && write_q)
    begin
      if (!match_q)
      begin
        port.host_dq_o    = wdata_q;
        port.host_dq_oe_n = '0;
      end
      else if (size_q)
      begin
        port.host_dq_o[8:0]    = wdata_q[idx_q*`RP_LANE_W +: `RP_LANE_W];
        port.host_dq_oe_n[8:0] = '0;
      end
      else
      begin
        port.host_dq_o[17:0]    = wdata_q[idx_q[0]*`RP_HALF_W +: `RP_HALF_W];
        port.host_dq_oe_n[17:0] = '0;
      end
    end
  end

  // Folds the piece now on the wire into the word gathered so far.
  always_comb
  begin
    rd_merge = rdata_q;
    if (size_q)
      rd_merge[rd_slot_q*`RP_LANE_W +: `RP_LANE_W] = port.mem_dq_o[`RP_LANE_W-1:0];
    else
      rd_merge[rd_slot_q[0]*`RP_HALF_W +: `RP_HALF_W] = port.mem_dq_o[`RP_HALF_W-1:0];
  end

  // Read pieces arrive one cycle after their request cycle.
  assign rd_idx = idx_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q      <= 1'b0;
      rd_slot_q <= 2'h0;
      rdata_q   <= '0;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end
    else
    begin
      rd_q      <= busy && !write_q;
      rd_slot_q <= rd_idx;
      rsp_valid <= 1'b0;
      if (busy && !write_q && (cnt_q == `RP_SUB_ZERO))
        rdata_q <= '0;
      if (rd_q)
      begin
        if (!match_q)
        begin
          rsp_data  <= port.mem_dq_o;
          rsp_valid <= 1'b1;
        end
        else
          rdata_q <= rd_merge;
      end
      // The final piece is folded in on the way out, so it is not lost.
      if (match_q && rd_q && !(busy && !write_q))
      begin
        rsp_valid <= 1'b1;
        rsp_data  <= rd_merge;
      end
    end
  end
endmodule

// File: core/bus_match_cfg.svh
// Constants for the right-port bus width matcher.
`ifndef BUS_MATCH_CFG_SVH
`define BUS_MATCH_CFG_SVH
`define RP_WORD_W    36
`define RP_LANE_W    9
`define RP_HALF_W    18
`define RP_SUB_W     2
`define RP_SUB_ZERO  2'h0
`define RP_SUB_LAST  2'h3
`define RP_SUB_HALF  2'h1
`define RP_SUB_STEP  2'h1
`define RP_SETUP_CYC 1
`endif

// File: core/bus_match_pkg.sv
// Types for the two ends of the right port: seq_t for the host, width_t for the memory.
package bus_match_pkg;
  typedef enum logic [2:0] {
    WIDTH_LONG = 3'b001,
    WIDTH_WORD = 3'b010,
    WIDTH_BYTE = 3'b100
  } width_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h1,
    SEQ_RUN  = 2'h2
  } seq_t;
endpackage

// File: core/right_port_if.sv
// Right-port pins joining the host controller and the memory end.
`timescale 1ns/1ps
interface right_port_if;
  logic        width_match_select; // High selects a narrow port.
  logic        size_select;        // High selects byte width when narrow.
  logic        lane_order_select;  // High selects big-endian order.
  logic        access;             // High while a transfer cycle runs.
  logic        write;              // High for write cycles.
  logic        first;              // High on the first cycle of a word.
  logic [35:0] host_dq_o;          // Host drive value.
  logic [35:0] host_dq_oe_n;       // Host enables, low drives.
  logic [35:0] mem_dq_o;           // Memory drive value.
  logic [35:0] mem_dq_oe_n;        // Memory enables, low drives.
  modport host (output width_match_select, size_select, lane_order_select, access, write,
                first, host_dq_o, host_dq_oe_n, input mem_dq_o, mem_dq_oe_n);
  modport mem (input width_match_select, size_select, lane_order_select, access, write,
               first, host_dq_o, host_dq_oe_n, output mem_dq_o, mem_dq_oe_n);
endinterface

// File: core/bus_match_mem.sv
// Memory end: steers one 36-bit word through the right-port lanes.
`timescale 1ns/1ps
`include "bus_match_cfg.svh"
module bus_match_mem (
  input  wire logic        clk,       // 10 MHz clock.
  input  wire logic        rst_n,     // Asynchronous reset, active low.
  right_port_if.mem        port,      // Right-port pins.
  input  wire logic [35:0] rd_word,   // Stored word to read out.
  output logic      [35:0] wr_word,   // Assembled word from writes.
  output logic             wr_valid,  // Pulse when a written word is whole.
  output logic             rd_next    // Pulse when a read word is consumed.
);
  bus_match_pkg::width_t           width;
  logic [`RP_SUB_W-1:0]            sub_q;
  logic [`RP_SUB_W-1:0]            sub_d;
  logic [`RP_SUB_W-1:0]            sub_start;
  logic [`RP_SUB_W-1:0]            sub_end;
  logic [`RP_SUB_W-1:0]            lane;
  logic                            big;
  logic [`RP_WORD_W-1:0]           dout_q;
  logic [`RP_WORD_W-1:0]           oe_n_q;
  logic [`RP_WORD_W-1:0]           asm_q;
  logic                            last;

  // Decode of the static width pins.
  always_comb
  begin
    if (!port.width_match_select)
      width = bus_match_pkg::WIDTH_LONG;
    else if (port.size_select)
      width = bus_match_pkg::WIDTH_BYTE;
    else
      width = bus_match_pkg::WIDTH_WORD;
  end

  // Order only matters when narrow; long-word ignores it.
  assign big = port.lane_order_select && (width != bus_match_pkg::WIDTH_LONG);

  // Start and end positions of the sub-counter per width and order.
  always_comb
  begin
    case (width)
      bus_match_pkg::WIDTH_WORD:
      begin
        sub_start = big ? `RP_SUB_HALF : `RP_SUB_ZERO;
        sub_end   = big ? `RP_SUB_ZERO : `RP_SUB_HALF;
      end
      bus_match_pkg::WIDTH_BYTE:
      begin
        sub_start = big ? `RP_SUB_LAST : `RP_SUB_ZERO;
        sub_end   = big ? `RP_SUB_ZERO : `RP_SUB_LAST;
      end
      default:
      begin
        sub_start = `RP_SUB_ZERO;
        sub_end   = `RP_SUB_ZERO;
      end
    endcase
  end

  // The current piece index: a first cycle restarts the sequence.
  assign lane = port.first ? sub_start : sub_q;
  assign last = port.access && (lane == sub_end);
  assign rd_next = last && !port.write;

  // Sub-counter steps up in little-endian, down in big-endian order.
  always_comb
  begin
    if (!port.access)
      sub_d = sub_q;
    else if (last)
      sub_d = sub_start;
    else if (big)
      sub_d = lane - `RP_SUB_STEP;
    else
      sub_d = lane + `RP_SUB_STEP;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sub_q <= `RP_SUB_ZERO;
    else
      sub_q <= sub_d;
  end

  // Read data and drive enables; unused lines stay undriven.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_q <= '0;
      oe_n_q <= '1;
    end
    else if (port.access && !port.write)
    begin
      case (width)
        bus_match_pkg::WIDTH_WORD:
        begin
          dout_q <= {{(`RP_WORD_W-`RP_HALF_W){1'h0}},
                     rd_word[lane[0]*`RP_HALF_W +: `RP_HALF_W]};
          oe_n_q <= {{(`RP_WORD_W-`RP_HALF_W){1'h1}}, {`RP_HALF_W{1'h0}}};
        end
        bus_match_pkg::WIDTH_BYTE:
        begin
          dout_q <= {{(`RP_WORD_W-`RP_LANE_W){1'h0}},
                     rd_word[lane*`RP_LANE_W +: `RP_LANE_W]};
          oe_n_q <= {{(`RP_WORD_W-`RP_LANE_W){1'h1}}, {`RP_LANE_W{1'h0}}};
        end
        default:
        begin
          dout_q <= rd_word;
          oe_n_q <= '0;
        end
      endcase
    end
    else
      oe_n_q <= '1;
  end

  assign port.mem_dq_o    = dout_q;
  assign port.mem_dq_oe_n = oe_n_q;

  // Written pieces are assembled into their place in the word.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      asm_q <= '0;
    else if (port.access && port.write)
    begin
      case (width)
        bus_match_pkg::WIDTH_WORD:
          asm_q[lane[0]*`RP_HALF_W +: `RP_HALF_W] <= port.host_dq_o[`RP_HALF_W-1:0];
        bus_match_pkg::WIDTH_BYTE:
          asm_q[lane*`RP_LANE_W +: `RP_LANE_W] <= port.host_dq_o[`RP_LANE_W-1:0];
        default:
          asm_q <= port.host_dq_o;
      endcase
    end
  end

  // Completed-word strobe for writes.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_valid <= 1'b0;
    else
      wr_valid <= last && port.write;
  end

  assign wr_word = asm_q;
endmodule

// File: bench/bus_match_chk.sv
// Concurrent checks on the right-port pins between the host and memory ends.
`timescale 1ns/1ps
module bus_match_chk (
  input wire logic        clk,                // Port clock.
  input wire logic        rst_n,              // Reset, active low.
  input wire logic        width_match_select, // Narrow port.
  input wire logic        size_select,        // Byte width when narrow.
  input wire logic        lane_order_select,  // Big-endian order.
  input wire logic        access,             // Transfer cycle.
  input wire logic        write,              // Write cycle.
  input wire logic        first,              // First piece of a word.
  input wire logic [35:0] host_dq_o,          // Host value.
  input wire logic [35:0] host_dq_oe_n,       // Host enables.
  input wire logic [35:0] mem_dq_o,           // Memory value.
  input wire logic [35:0] mem_dq_oe_n         // Memory enables.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic byte_m;
  logic word_m;
  logic long_m;
  // Decodes the width from the two select pins.
  assign byte_m = width_match_select && size_select;
  assign word_m = width_match_select && !size_select;
  assign long_m = !width_match_select && !size_select;
  sequence word_go;
    access && first && word_m;
  endsequence
  sequence byte_go;
    access && first && byte_m;
  endsequence
  a_word_span: assert property (word_go |-> ##1 (access && !first) ##1 !access)
    else $error("word transfer length wrong");
  a_byte_span: assert property (byte_go |-> ##1 (access && !first) [*3] ##1 !access)
    else $error("byte transfer length wrong");
  a_long_single: assert property (access && long_m |-> first ##1 !access)
    else $error("long transfer not single");
  a_byte_float: assert property (byte_m |-> (&mem_dq_oe_n[35:9]) && (&host_dq_oe_n[35:9]))
    else $error("upper lines driven in byte width");
  a_word_float: assert property (word_m |-> (&mem_dq_oe_n[35:18]) && (&host_dq_oe_n[35:18]))
    else $error("upper lines driven in word width");
  a_long_read: assert property (access && !write && long_m |=> mem_dq_oe_n == 36'h0)
    else $error("long read not on all lines");
  a_word_read: assert property (access && !write && word_m |=> mem_dq_oe_n[17:0] == 18'h0)
    else $error("word read not on low lines");
  a_byte_read: assert property (access && !write && byte_m |=> mem_dq_oe_n[8:0] == 9'h0)
    else $error("byte read not on low lines");
  a_write_lanes: assert property (access && write |-> host_dq_oe_n[8:0] == 9'h0 && &mem_dq_oe_n)
    else $error("write lanes not driven by host alone");
  a_sel_steady: assert property (access |-> $stable(width_match_select) && $stable(size_select)
    && $stable(lane_order_select))
    else $error("selects moved during transfer");
endmodule

// File: bench/dual_port_ram_bus_width_matcher_tb_top.sv
// Bench joining both right-port ends and checking every width and order.
`timescale 1ns/1ps
module dual_port_ram_bus_width_matcher_tb_top;
  logic        clk;          // Port clock.
  logic        rst_n;        // Reset, active low.
  logic        cfg_match;    // Narrow port.
  logic        cfg_size;     // Byte width.
  logic        cfg_order;    // Big-endian order.
  logic        req;          // Start a word.
  logic        req_write;    // Word is a write.
  logic [35:0] req_data;     // Word to write.
  logic [35:0] rd_word;      // Stored word for reads.
  logic        ready;        // Host idle.
  logic [35:0] rsp_data;     // Word read back.
  logic        rsp_valid;    // Read done.
  logic [35:0] wr_word;      // Word assembled.
  logic        wr_valid;     // Write done.
  logic        rd_next;      // Read word consumed.
  logic [35:0] piece [0:3];  // Pieces seen on the wire.
  int          npc;          // Pieces seen.
  int          nrn;          // Read strobes seen.
  int          mismatches;   // Failed comparisons.
  int          check_count;  // All comparisons.
  int          pcs [0:2] = '{1, 2, 4};
  int          wid [0:2] = '{36, 18, 9};
  right_port_if right_port_if_inst ();
  bus_match_host bus_match_host_inst (.clk(clk), .rst_n(rst_n), .port(right_port_if_inst.host),
    .cfg_match(cfg_match), .cfg_size(cfg_size), .cfg_order(cfg_order), .req(req),
    .req_write(req_write), .req_data(req_data), .ready(ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid));
  bus_match_mem bus_match_mem_inst (.clk(clk), .rst_n(rst_n), .port(right_port_if_inst.mem),
    .rd_word(rd_word), .wr_word(wr_word), .wr_valid(wr_valid), .rd_next(rd_next));
  bus_match_chk bus_match_chk_inst (.clk(clk), .rst_n(rst_n),
    .width_match_select(right_port_if_inst.width_match_select),
    .size_select(right_port_if_inst.size_select),
    .lane_order_select(right_port_if_inst.lane_order_select),
    .access(right_port_if_inst.access), .write(right_port_if_inst.write),
    .first(right_port_if_inst.first), .host_dq_o(right_port_if_inst.host_dq_o),
    .host_dq_oe_n(right_port_if_inst.host_dq_oe_n), .mem_dq_o(right_port_if_inst.mem_dq_o),
    .mem_dq_oe_n(right_port_if_inst.mem_dq_oe_n));
  // Makes the 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Collects each piece from whichever side drives the wire, at mid-cycle.
  always @(negedge clk)
  begin
    if (npc < 4 && right_port_if_inst.access === 1'b1 && right_port_if_inst.write === 1'b1)
    begin
      piece[npc] = right_port_if_inst.host_dq_o;
      npc = npc + 1;
    end
    else if (npc < 4 && right_port_if_inst.mem_dq_oe_n[0] === 1'b0)
    begin
      piece[npc] = right_port_if_inst.mem_dq_o;
      npc = npc + 1;
    end
  end
  // Counts read-word-consumed strobes from the memory end, at mid-cycle.
  always @(negedge clk)
    if (rd_next === 1'b1)
      nrn = nrn + 1;
  task automatic cmp_word(input string what, input logic [35:0] exp, input logic [35:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Moves one word and checks the word, the piece count and each piece in order.
  task automatic xfer(input logic wr, input logic [35:0] w, input int n, input int pw);
    int i;
    logic [35:0] m;
    m = (36'h1 << pw) - 36'h1;
    i = 0;
    while (ready !== 1'b1 && i < 50)
    begin
      @(negedge clk);
      i = i + 1;
    end
    cmp_word("ready wait", 36'h0, (i >= 50) ? 36'h1 : 36'h0);
    npc = 0;
    nrn = 0;
    @(posedge clk);
    req <= 1'b1;
    req_write <= wr;
    req_data <= w;
    rd_word <= w;
    @(posedge clk);
    req <= 1'b0;
    i = 0;
    while ((wr ? wr_valid : rsp_valid) !== 1'b1 && i < 50)
    begin
      @(negedge clk);
      i = i + 1;
    end
    cmp_word("done wait", 36'h0, (i >= 50) ? 36'h1 : 36'h0);
    cmp_word("word", w, wr ? wr_word : rsp_data);
    cmp_word("piece count", n, npc);
    cmp_word("read strobes", wr ? 36'h0 : 36'h1, nrn);
    for (i = 0; i < n; i++)
      cmp_word("piece", (w >> (pw * ((cfg_order && n > 1) ? n - 1 - i : i))) & m,
               piece[i] & m);
  endtask
  // Resets, then walks every width with both orders, writes and reads back to back.
  initial
  begin
    rst_n = 1'b0;
    cfg_match = 1'b0;
    cfg_size = 1'b0;
    cfg_order = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_data = 36'h0;
    rd_word = 36'h0;
    mismatches = 0;
    check_count = 0;
    npc = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk);
      cfg_match <= (k > 1);
      cfg_size <= (k > 3);
      cfg_order <= k[0];
      repeat (3) @(negedge clk);
      xfer(1'b1, 36'h9A5C31E7D ^ k, pcs[k / 2], wid[k / 2]);
      xfer(1'b0, 36'h63B8FD204 + k, pcs[k / 2], wid[k / 2]);
    end
    stop_test();
  end
  // Cuts a hang short well after the tests should have ended.
  initial
  begin
    #(2000 * 100);
    mismatches = mismatches + 1;
    stop_test();
  end
endmodule
